// ### hw/rxef_pkg.sv
// Purpose: shared constants for the receiver error flag register bank
// Assumes: axi4-lite, 32-bit data, byte addresses = 4 * register index
// Notes: offsets are register indices; byte address derived below
package rxef_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned FLAG_W = 7;
  // register indices and byte addresses
  localparam logic [ADDR_W-1:0] IDX_FLAGS = 8'h10;
  localparam logic [ADDR_W-1:0] IDX_MASK = 8'h11;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 8'h12;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 8'h13;
  localparam logic [ADDR_W-1:0] IDX_CTRL = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h44;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h48;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h4C;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h50;
  // flag bit positions
  localparam int unsigned BIT_PARITY = 0;
  localparam int unsigned BIT_BIPHASE = 1;
  localparam int unsigned BIT_CONF = 2;
  localparam int unsigned BIT_VALID = 3;
  localparam int unsigned BIT_UNLOCK = 4;
  localparam int unsigned BIT_CSCRC = 5;
  localparam int unsigned BIT_SUBCODE_CRC = 6;
  // bits that may disturb the audio sample (all but the two crc flags)
  localparam logic [FLAG_W-1:0] SAMPLE_AFFECT = 7'h1F;
  // reset values and the ctrl hold bit position
  localparam logic [FLAG_W-1:0] RST_FLAGS = 7'h00;
  localparam logic [FLAG_W-1:0] RST_MASK = 7'h00;
  localparam logic RST_HOLD_ZERO = 1'b0;
  localparam int unsigned CTRL_HOLD_BIT = 0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### hw/rxef_sample_gate.sv
// Purpose: apply the error policy to the current audio sample
// Assumes: sample_in is valid in the cycle sample_valid is high
// Notes: hold=0 repeats last good sample, hold=1 replaces with zero
`timescale 1ns/1ns
module rxef_sample_gate #(
  parameter int unsigned SAMPLE_W = 24
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // policy
  input wire logic sample_error,
  input wire logic hold_zero,
  // sample stream
  input wire logic sample_valid,
  input wire logic [SAMPLE_W-1:0] sample_in,
  output logic [SAMPLE_W-1:0] sample_out
);
  initial begin
    if (SAMPLE_W < 1 || SAMPLE_W > 32) begin
      $error("rxef_sample_gate: SAMPLE_W out of range");
    end
  end

  logic [SAMPLE_W-1:0] last_good;
  wire logic [SAMPLE_W-1:0] repl = hold_zero ? '0 : last_good;
  wire logic [SAMPLE_W-1:0] next_out = sample_error ? repl : sample_in;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_good <= '0;
      sample_out <= '0;
    end else if (sample_valid) begin
      sample_out <= next_out;
      if (!sample_error) begin
        last_good <= sample_in;
      end
    end
  end
endmodule

// ### hw/rxef_top.sv
// Purpose: receiver error flag register, enable mask, error pin and irq
// Assumes: error sources and boundary strobes synchronous to aclk
// Notes: registers reached over axi4-lite; one write, one read at a time
`timescale 1ns/1ns
module rxef_top #(
  parameter int unsigned SAMPLE_W = 24
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // error sources from the receiver, levels
  input wire logic subcode_crc_error,
  input wire logic chan_status_crc_error,
  input wire logic pll_unlocked,
  input wire logic validity_error,
  input wire logic eye_conf_error,
  input wire logic line_code_error,
  input wire logic subframe_check_error,
  // boundary strobes, one-cycle pulses, and the professional mode level
  input wire logic q_block_boundary,
  input wire logic cs_block_boundary,
  input wire logic subframe_boundary,
  input wire logic professional_mode,
  // audio sample path
  input wire logic sample_valid,
  input wire logic [SAMPLE_W-1:0] sample_in,
  output logic [SAMPLE_W-1:0] sample_out,
  // outputs
  output logic rx_error_out,
  output logic irq
);
  localparam int unsigned FW = rxef_pkg::FLAG_W;

  // error sources sampled at boundaries (eye margin every cycle) and register state
  logic [FW-1:0] src;
  logic [FW-1:0] flags;
  logic [FW-1:0] mask;
  logic [FW-1:0] irq_status;
  logic [FW-1:0] irq_mask;
  logic hold_zero;
  logic [FW-1:0] src_prev;

  // per-bit update strobes
  wire logic [FW-1:0] upd;
  assign upd[rxef_pkg::BIT_SUBCODE_CRC] = q_block_boundary;
  assign upd[rxef_pkg::BIT_CSCRC] = cs_block_boundary;
  assign upd[rxef_pkg::BIT_UNLOCK] = cs_block_boundary;
  assign upd[rxef_pkg::BIT_VALID] = subframe_boundary;
  assign upd[rxef_pkg::BIT_BIPHASE] = subframe_boundary;
  assign upd[rxef_pkg::BIT_PARITY] = subframe_boundary;
  // eye margin is a continuous measurement, tracked every cycle
  assign upd[rxef_pkg::BIT_CONF] = 1'b1;

  wire logic [FW-1:0] raw;
  assign raw[rxef_pkg::BIT_SUBCODE_CRC] = subcode_crc_error;
  // the cs crc only carries meaning for professional-format data
  assign raw[rxef_pkg::BIT_CSCRC] = chan_status_crc_error
    & professional_mode;
  assign raw[rxef_pkg::BIT_UNLOCK] = pll_unlocked;
  assign raw[rxef_pkg::BIT_VALID] = validity_error;
  assign raw[rxef_pkg::BIT_CONF] = eye_conf_error;
  assign raw[rxef_pkg::BIT_BIPHASE] = line_code_error;
  assign raw[rxef_pkg::BIT_PARITY] = subframe_check_error;

  wire logic [FW-1:0] next_src;
  wire logic [FW-1:0] active = next_src & mask;

  // axi handshake state
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  wire logic aw_fire = awvalid && awready;
  wire logic w_fire = wvalid && wready;
  wire logic have_aw = aw_held || aw_fire;
  wire logic have_w = w_held || w_fire;
  wire logic wr_go = have_aw && have_w;
  wire logic [7:0] wr_addr = aw_held ? aw_addr_q : awaddr;
  wire logic [31:0] wr_data = w_held ? w_data_q : wdata;
  wire logic [3:0] wr_strb = w_held ? w_strb_q : wstrb;
  wire logic wr_lane0 = wr_go && wr_strb[0];

  wire logic wr_mask = wr_lane0 && wr_addr == rxef_pkg::ADDR_MASK;
  wire logic wr_istat = wr_lane0 && wr_addr == rxef_pkg::ADDR_IRQ_STATUS;
  wire logic wr_imask = wr_lane0 && wr_addr == rxef_pkg::ADDR_IRQ_MASK;
  wire logic wr_ctrl = wr_lane0 && wr_addr == rxef_pkg::ADDR_CTRL;
  wire logic wr_hit = wr_addr == rxef_pkg::ADDR_FLAGS
    || wr_addr == rxef_pkg::ADDR_MASK
    || wr_addr == rxef_pkg::ADDR_IRQ_STATUS
    || wr_addr == rxef_pkg::ADDR_IRQ_MASK
    || wr_addr == rxef_pkg::ADDR_CTRL;

  assign arready = !rvalid;
  wire logic ar_fire = arvalid && arready;
  wire logic rd_flags = ar_fire && araddr == rxef_pkg::ADDR_FLAGS;

  genvar i;
  generate
    for (i = 0; i < FW; i++) begin : g_src
      assign next_src[i] = upd[i] ? raw[i] : src[i];
    end
  endgenerate

  // read clears, but an active source or a new event wins over the clear
  wire logic [FW-1:0] kept = rd_flags ? '0 : flags;
  wire logic [FW-1:0] next_flags = (kept | active) & mask;

  wire logic [FW-1:0] rise = active & ~src_prev;
  wire logic [FW-1:0] istat_clr = wr_istat ? wr_data[FW-1:0] : '0;
  wire logic [FW-1:0] next_istat = (irq_status & ~istat_clr) | rise;

  wire logic [31:0] rd_mux =
    araddr == rxef_pkg::ADDR_FLAGS ? {25'h000_0000, flags & mask} :
    araddr == rxef_pkg::ADDR_MASK ? {25'h000_0000, mask} :
    araddr == rxef_pkg::ADDR_IRQ_STATUS ? {25'h000_0000, irq_status} :
    araddr == rxef_pkg::ADDR_IRQ_MASK ? {25'h000_0000, irq_mask} :
    araddr == rxef_pkg::ADDR_CTRL ? {31'h0000_0000, hold_zero} :
    32'h0000_0000;
  wire logic rd_hit = araddr == rxef_pkg::ADDR_FLAGS
    || araddr == rxef_pkg::ADDR_MASK
    || araddr == rxef_pkg::ADDR_IRQ_STATUS
    || araddr == rxef_pkg::ADDR_IRQ_MASK
    || araddr == rxef_pkg::ADDR_CTRL;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src <= '0;
      src_prev <= '0;
      flags <= rxef_pkg::RST_FLAGS;
      mask <= rxef_pkg::RST_MASK;
      irq_status <= '0;
      irq_mask <= '0;
      hold_zero <= rxef_pkg::RST_HOLD_ZERO;
    end else begin
      src <= next_src;
      src_prev <= active;
      flags <= next_flags;
      irq_status <= next_istat;
      if (wr_mask) begin
        mask <= wr_data[FW-1:0];
      end
      if (wr_imask) begin
        irq_mask <= wr_data[FW-1:0];
      end
      if (wr_ctrl) begin
        hold_zero <= wr_data[rxef_pkg::CTRL_HOLD_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= rxef_pkg::RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? rxef_pkg::RESP_OKAY : rxef_pkg::RESP_SLVERR;
      end else begin
        if (aw_fire) begin
          aw_held <= 1'b1;
          aw_addr_q <= awaddr;
        end
        if (w_fire) begin
          w_held <= 1'b1;
          w_data_q <= wdata;
          w_strb_q <= wstrb;
        end
        if (bvalid && bready) begin
          bvalid <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= rxef_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_hit ? rxef_pkg::RESP_OKAY : rxef_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // pin follows live enabled errors; irq follows sticky unmasked status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_error_out <= 1'b0;
      irq <= 1'b0;
    end else begin
      rx_error_out <= |active;
      irq <= |(next_istat & irq_mask);
    end
  end

  wire logic sample_error = |(active & rxef_pkg::SAMPLE_AFFECT);

  rxef_sample_gate #(
    .SAMPLE_W(SAMPLE_W)
  ) u_gate (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_error(sample_error),
    .hold_zero(hold_zero),
    .sample_valid(sample_valid),
    .sample_in(sample_in),
    .sample_out(sample_out)
  );
endmodule

// ### verif/rxef_properties.sv
// Purpose: port checker for the receiver error flag bank
// Assumes: the master offers write address and data together
// Notes: mask shadow follows completed mask writes only
`timescale 1ns/1ns
module rxef_properties #(
  parameter int unsigned SAMPLE_W = 24
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus, grouped to keep the bind short
  input wire logic awvalid, awready, wvalid, wready, bvalid,
  input wire logic arvalid, arready, rvalid,
  input wire logic [7:0] awaddr, araddr,
  input wire logic [31:0] wdata, rdata,
  input wire logic [3:0] wstrb,
  // receiver side
  input wire logic eye_conf_error, sample_valid, rx_error_out, irq,
  input wire logic [SAMPLE_W-1:0] sample_in, sample_out
);
  logic [6:0] mq;
  logic rdf;
  wire wr_hit = awvalid && awready && wvalid && wready;
  wire ar_hit = arvalid && arready;
  wire mask_wr = wr_hit && awaddr == rxef_pkg::ADDR_MASK && wstrb[0];
  wire [6:0] aff = mq & rxef_pkg::SAMPLE_AFFECT;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mq <= '0;
      rdf <= 1'b0;
    end else begin
      if (mask_wr) mq <= wdata[6:0];
      if (ar_hit) rdf <= araddr == rxef_pkg::ADDR_FLAGS;
    end
  end
  bit7_zero_a: assert property (rvalid |-> rdata[31:7] == '0)
    else $error("upper read bits not zero");
  flag_masked_a: assert property (rvalid && rdf |-> (rdata[6:0] & ~mq) == '0)
    else $error("masked flag reads one");
  pin_masked_a: assert property ((mq == '0) [*3] |-> !rx_error_out)
    else $error("error pin with all masked");
  sample_pass_a: assert property (sample_valid && aff == '0 |=>
    sample_out == $past(sample_in)) else $error("sample altered");
  conf_pin_a: assert property ((eye_conf_error && mq[2]) [*4] |->
    rx_error_out) else $error("error pin missing");
  reset_out_a: assert property ($rose(aresetn) |-> !rx_error_out &&
    !irq && sample_out == '0) else $error("outputs not cleared");
  rd_answer_a: assert property (ar_hit |=> rvalid)
    else $error("read not answered");
  wr_answer_a: assert property (wr_hit |=> bvalid)
    else $error("write not answered");
  cover property (rvalid && rdf && rdata != '0);
  cover property (rx_error_out);
  cover property (irq);
endmodule
bind rxef_top rxef_properties #(.SAMPLE_W(SAMPLE_W)) rxef_properties_inst (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .awaddr(awaddr), .araddr(araddr),
  .wdata(wdata), .rdata(rdata), .wstrb(wstrb), .irq(irq),
  .eye_conf_error(eye_conf_error), .sample_valid(sample_valid),
  .rx_error_out(rx_error_out), .sample_in(sample_in),
  .sample_out(sample_out));

// ### verif/rxef_top_test.sv
// Purpose: self-checking bench for the receiver error flag bank
// Assumes: one write or one read under way at a time
// Notes: random masks and samples, fixed corner cases among them
`timescale 1ns/1ns
module rxef_top_test;
  logic aclk = 0, aresetn = 0, bnd = 0, sample_valid = 0, prof = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [6:0] err = 0, m, e;
  logic [23:0] sample_in = 0, sample_out, good, d;
  logic awready, wready, bvalid, arready, rvalid, rx_error_out, irq;
  logic [1:0] bresp, rresp;
  int n_mismatch = 0, check_count = 0, seed = 32'hde19_8928;
  initial forever #2 aclk = ~aclk;
  rxef_top rxef_top_inst (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp),
    .subcode_crc_error(err[6]), .chan_status_crc_error(err[5]),
    .pll_unlocked(err[4]), .validity_error(err[3]),
    .eye_conf_error(err[2]), .line_code_error(err[1]),
    .subframe_check_error(err[0]), .q_block_boundary(bnd),
    .cs_block_boundary(bnd), .subframe_boundary(bnd),
    .professional_mode(prof), .sample_valid(sample_valid),
    .sample_in(sample_in), .sample_out(sample_out),
    .rx_error_out(rx_error_out), .irq(irq));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // a wait that runs out ends the run at once
  task automatic tmo(input logic ok);
    if (!ok) begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    tmo(i < 64);
    chk({30'h0, bresp}, {30'h0, rxef_pkg::RESP_OKAY});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    tmo(i < 64);
    chk(rdata, x);
    chk({30'h0, rresp}, {30'h0, r});
  endtask
  task automatic rf(input logic [6:0] x);
    rd(rxef_pkg::ADDR_FLAGS, {25'h0, x}, rxef_pkg::RESP_OKAY);
  endtask
  // source held for one boundary, then dropped unless kept
  task automatic ev(input logic [6:0] v, input logic keep);
    @(posedge aclk);
    err <= v;
    bnd <= 1'b1;
    @(posedge aclk);
    bnd <= 1'b0;
    if (!keep) err <= '0;
    @(posedge aclk);
    bnd <= 1'b1;
    @(posedge aclk);
    bnd <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic smp(input logic [23:0] v, input logic [23:0] x);
    @(posedge aclk);
    sample_in <= v;
    sample_valid <= 1'b1;
    @(posedge aclk);
    sample_valid <= 1'b0;
    @(posedge aclk);
    chk({8'h0, sample_out}, {8'h0, x});
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rf('0);
    rd(rxef_pkg::ADDR_MASK, '0, rxef_pkg::RESP_OKAY);
    rd(8'h7c, '0, rxef_pkg::RESP_SLVERR);
    wr(rxef_pkg::ADDR_IRQ_MASK, 32'h7f);
    for (int k = 0; k < 2; k++) begin
      for (int b = 0; b < 7; b++) begin
        e = 7'h01 << b;
        m = 7'($random(seed));
        m[b] = k[0] ^ b[0];
        wr(rxef_pkg::ADDR_MASK, {25'h0, m});
        rd(rxef_pkg::ADDR_MASK, {25'h0, m}, rxef_pkg::RESP_OKAY);
        ev(e, 1'b0);
        chk({31'h0, irq}, {31'h0, |(e & m)});
        rf(e & m);
        rf('0);
        wr(rxef_pkg::ADDR_IRQ_STATUS, 32'h7f);
        ev(e, 1'b1);
        chk({31'h0, rx_error_out}, {31'h0, |(e & m)});
        rf(e & m);
        rf(e & m);
        ev('0, 1'b0);
        rf(e & m);
        wr(rxef_pkg::ADDR_IRQ_STATUS, 32'h7f);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, '0);
        $display("flag bit %0d pass %0d done", b, k);
      end
    end
    wr(rxef_pkg::ADDR_MASK, 32'h7f);
    good = 24'($random(seed));
    d = 24'($random(seed));
    smp(good, good);
    ev(7'h01, 1'b1);
    smp(d, good);
    wr(rxef_pkg::ADDR_CTRL, 32'h1);
    smp(d, '0);
    ev(7'h60, 1'b1);
    smp(d, d);
    wr(rxef_pkg::ADDR_MASK, '0);
    ev(7'h1f, 1'b1);
    smp(good, good);
    rf('0);
    ev('0, 1'b0);
    $display("sample test done");
    // cs crc only counts for professional-format data
    wr(rxef_pkg::ADDR_MASK, 32'h20);
    prof <= 1'b0;
    ev(7'h20, 1'b0);
    rf('0);
    prof <= 1'b1;
    ev(7'h20, 1'b0);
    rf(7'h20);
    $display("professional mode test done");
    give_verdict();
  end
endmodule
